// ===== design/lane_mover_pkg.sv
/*
  Shared constants and carrier types for the lane data mover.
  Assumes a single 25 MHz core clock and an active-low asynchronous reset.
*/
package lane_mover_pkg;
  localparam int unsigned CHANNELS      = 8;
  localparam int unsigned BYTE_W        = 8;
  localparam int unsigned LANE_RATE_MHZ = 100;
  localparam int unsigned CORE_CLK_MHZ  = 25;
  localparam int unsigned SLOW_GAP      = 3;
  localparam int unsigned FIFO_DEPTH    = 16;
  localparam int unsigned ALMOST_MARGIN = 4;
  localparam int unsigned SKID_DEPTH    = 2;

  typedef struct packed {
    logic              valid;
    logic [BYTE_W-1:0] data;
  } lane_word_s;

  typedef struct packed {
    logic full;
    logic almost_full;
  } lane_flags_s;

  typedef enum logic [1:0] {
    MV_IDLE,
    MV_BURST,
    MV_SETTLE
  } mover_state_e;
endpackage

// ===== design/lane_mover.sv
/*
  Eight-channel push data mover between controller FIFOs and user-logic FIFOs.
  Assumes the far engines keep to the full flag presented on each receive lane.
*/
// Summary of operation
// - Each channel owns one transmit lane and one receive lane, each one-way.
// - The controller offers eight transmit FIFO paths and eight receive FIFO paths.
// - Every transmit path runs on its own logic so all channels transmit at once; receive drains share one bus.
// - The receiving side of a lane shows full and almost-full to the engine feeding it.
// - The sender pushes from its own FIFO into the target FIFO; the target never pulls.
// - With source not almost empty and target not almost full one byte moves per clock.
// - When source is almost empty or target almost full the engine slows to settled status.
// - In slow steps the engine waits out the status latency after each write before trusting the flags.
// - An arbiter shares the intermediate bus among channel engines with no software.
// - Each lane carries eight bits per transfer in its one direction.
`timescale 1ns/1ps
module lane_mover
  import lane_mover_pkg::*;
#(
  parameter int unsigned DEPTH  = FIFO_DEPTH,
  parameter int unsigned MARGIN = ALMOST_MARGIN
)(
  // Clock and reset
  input  wire logic                       core_clk_in,
  input  wire logic                       arst_n_in,
  // Host-side transmit fill, per channel
  input  wire lane_word_s  [CHANNELS-1:0] tx_fill_in,
  output logic             [CHANNELS-1:0] tx_fill_ready_out,
  // Transmit lanes toward user logic
  output lane_word_s       [CHANNELS-1:0] tx_lane_out,
  input  wire lane_flags_s [CHANNELS-1:0] tx_target_flags_in,
  // Receive lanes from user logic
  input  wire lane_word_s  [CHANNELS-1:0] rx_lane_in,
  output lane_flags_s      [CHANNELS-1:0] rx_flags_out,
  // Host-side receive drain, shared bus
  output lane_word_s                      rx_bus_out,
  output logic             [2:0]          rx_bus_chan_out,
  input  wire logic                       rx_bus_ready_in
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = AW + 1;

  function automatic logic [CW-1:0] inc_cnt(input logic [CW-1:0] c);
    return c + CW'(1);
  endfunction

  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++)
    begin : g_chan
      // Transmit source FIFO
      logic [BYTE_W-1:0]  tx_mem_q [DEPTH];
      logic [AW-1:0]      tx_wp_q;
      logic [AW-1:0]      tx_rp_q;
      logic [CW-1:0]      tx_cnt_q;
      logic               tx_push;
      logic               tx_pop;
      logic               src_aempty;
      mover_state_e       st_q;
      logic [1:0]         gap_q;
      lane_word_s         lane_q;
      logic               fill_rdy_q;

      assign tx_push    = tx_fill_in[g].valid && fill_rdy_q;
      assign src_aempty = tx_cnt_q <= CW'(MARGIN);
      // Burst only while both margins hold; settle otherwise
      assign tx_pop = (tx_cnt_q != '0) && !tx_target_flags_in[g].full &&
                      ((st_q == MV_BURST) || (st_q == MV_IDLE && gap_q == '0));

      always_ff @(posedge core_clk_in)
      begin
        if (tx_push)
        begin
          tx_mem_q[tx_wp_q] <= tx_fill_in[g].data;
        end
      end

      always_ff @(posedge core_clk_in or negedge arst_n_in)
      begin
        if (!arst_n_in)
        begin
          tx_wp_q    <= '0;
          tx_rp_q    <= '0;
          tx_cnt_q   <= '0;
          fill_rdy_q <= 1'b0;
        end
        else
        begin
          if (tx_push)
          begin
            tx_wp_q <= tx_wp_q + AW'(1);
          end
          if (tx_pop)
          begin
            tx_rp_q <= tx_rp_q + AW'(1);
          end
          case ({tx_push, tx_pop})
            2'b10:   tx_cnt_q <= inc_cnt(tx_cnt_q);
            2'b01:   tx_cnt_q <= tx_cnt_q - CW'(1);
            default: tx_cnt_q <= tx_cnt_q;
          endcase
          // Registered ready keeps one spare slot for the in-flight push
          fill_rdy_q <= (tx_cnt_q + CW'(tx_push)) < CW'(DEPTH - 1);
        end
      end

      // Rate engine: burst or single steps with a settle gap
      always_ff @(posedge core_clk_in or negedge arst_n_in)
      begin
        if (!arst_n_in)
        begin
          st_q  <= MV_IDLE;
          gap_q <= '0;
        end
        else
        begin
          case (st_q)
            MV_IDLE:
            begin
              if (gap_q != '0)
              begin
                gap_q <= gap_q - 2'd1;
              end
              else if (!src_aempty && !tx_target_flags_in[g].almost_full)
              begin
                st_q <= MV_BURST;
              end
              else if (tx_pop)
              begin
                st_q  <= MV_SETTLE;
                gap_q <= 2'(SLOW_GAP - 1);
              end
            end
            MV_BURST:
            begin
              if (src_aempty || tx_target_flags_in[g].almost_full)
              begin
                st_q  <= MV_SETTLE;
                gap_q <= 2'(SLOW_GAP - 1);
              end
            end
            MV_SETTLE:
            begin
              // Status lags a write; wait before acting on it
              if (gap_q == '0)
              begin
                st_q <= MV_IDLE;
              end
              else
              begin
                gap_q <= gap_q - 2'd1;
              end
            end
            default:
            begin
              st_q  <= MV_IDLE;
              gap_q <= '0;
            end
          endcase
        end
      end

      always_ff @(posedge core_clk_in or negedge arst_n_in)
      begin
        if (!arst_n_in)
        begin
          lane_q <= '0;
        end
        else
        begin
          lane_q.valid <= tx_pop;
          lane_q.data  <= tx_mem_q[tx_rp_q];
        end
      end

      assign tx_lane_out[g]       = lane_q;
      assign tx_fill_ready_out[g] = fill_rdy_q;
    end
  endgenerate

  // Receive side: two-entry buffer per channel, drained over one shared bus
  logic [BYTE_W-1:0] rx_buf_q [CHANNELS][SKID_DEPTH];
  logic [1:0]        rx_cnt_q [CHANNELS];
  logic              rx_rp_q  [CHANNELS];
  logic              rx_wp_q  [CHANNELS];
  lane_flags_s [CHANNELS-1:0] rx_flags_q;
  logic [2:0]        grant_q;
  logic [2:0]        pick;
  logic              pick_ok;
  lane_word_s        bus_q;
  logic [2:0]        bus_chan_q;
  logic              bus_take;

  // Bus slot frees when empty or accepted
  assign bus_take = !bus_q.valid || rx_bus_ready_in;

  // Round robin from the channel after the last grant
  always_comb
  begin
    logic [2:0] c;
    c       = '0;
    pick    = '0;
    pick_ok = 1'b0;
    for (int i = 1; i <= CHANNELS; i++)
    begin
      c = 3'(grant_q + 3'(i));
      if (!pick_ok && rx_cnt_q[c] != 2'd0)
      begin
        pick    = c;
        pick_ok = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    for (int k = 0; k < CHANNELS; k++)
    begin
      if (rx_lane_in[k].valid && rx_cnt_q[k] != 2'(SKID_DEPTH))
      begin
        rx_buf_q[k][rx_wp_q[k]] <= rx_lane_in[k].data;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      for (int k = 0; k < CHANNELS; k++)
      begin
        rx_cnt_q[k] <= '0;
        rx_rp_q[k]  <= 1'b0;
        rx_wp_q[k]  <= 1'b0;
      end
      rx_flags_q <= '0;
    end
    else
    begin
      for (int k = 0; k < CHANNELS; k++)
      begin
        logic wr;
        logic rd;
        logic [1:0] nx;
        // Writes while full are dropped; the far engine must honor full
        wr = rx_lane_in[k].valid && rx_cnt_q[k] != 2'(SKID_DEPTH);
        rd = bus_take && pick_ok && (pick == 3'(k));
        nx = rx_cnt_q[k] + 2'(wr) - 2'(rd);
        rx_cnt_q[k] <= nx;
        if (wr)
        begin
          rx_wp_q[k] <= !rx_wp_q[k];
        end
        if (rd)
        begin
          rx_rp_q[k] <= !rx_rp_q[k];
        end
        rx_flags_q[k].full        <= nx == 2'(SKID_DEPTH);
        rx_flags_q[k].almost_full <= nx != 2'd0;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      bus_q      <= '0;
      bus_chan_q <= '0;
      grant_q    <= 3'(CHANNELS - 1);
    end
    else if (bus_take)
    begin
      bus_q.valid <= pick_ok;
      bus_q.data  <= rx_buf_q[pick][rx_rp_q[pick]];
      bus_chan_q  <= pick;
      if (pick_ok)
      begin
        grant_q <= pick;
      end
    end
  end

  assign rx_flags_out    = rx_flags_q;
  assign rx_bus_out      = bus_q;
  assign rx_bus_chan_out = bus_chan_q;

  // Loopback of lanes is a user-logic feature and needs no logic here

  property p_no_write_full;
    @(posedge core_clk_in) disable iff (!arst_n_in)
      tx_lane_out[0].valid |-> !$past(tx_target_flags_in[0].full);
  endproperty
  a_no_write_full: assert property (p_no_write_full)
    else $error("write issued into full target");

  property p_full_flag;
    @(posedge core_clk_in) disable iff (!arst_n_in)
      rx_flags_out[0].full |-> rx_cnt_q[0] == 2'd2;
  endproperty
  a_full_flag: assert property (p_full_flag)
    else $error("full flag without two stored words");

  property p_full_implies_af;
    @(posedge core_clk_in) disable iff (!arst_n_in)
      rx_flags_out[0].full |-> rx_flags_out[0].almost_full;
  endproperty
  a_full_implies_af: assert property (p_full_implies_af)
    else $error("full without almost full");

  property p_settle_gap;
    @(posedge core_clk_in) disable iff (!arst_n_in)
      (g_chan[0].st_q == MV_BURST) ##1 (g_chan[0].st_q == MV_SETTLE)
        |=> !g_chan[0].tx_pop [*2];
  endproperty
  a_settle_gap: assert property (p_settle_gap)
    else $error("pop during settle gap");

  property p_burst_rate;
    @(posedge core_clk_in) disable iff (!arst_n_in)
      (g_chan[1].st_q == MV_BURST && g_chan[1].tx_cnt_q != '0 &&
       !tx_target_flags_in[1].full) |=> tx_lane_out[1].valid;
  endproperty
  a_burst_rate: assert property (p_burst_rate)
    else $error("burst cycle without a byte");

  property p_bus_hold;
    @(posedge core_clk_in) disable iff (!arst_n_in)
      (rx_bus_out.valid && !rx_bus_ready_in) |=>
        (rx_bus_out.valid && $stable(rx_bus_out.data) && $stable(rx_bus_chan_out));
  endproperty
  a_bus_hold: assert property (p_bus_hold)
    else $error("bus word changed while stalled");

  property p_arb_served;
    @(posedge core_clk_in) disable iff (!arst_n_in)
      (rx_cnt_q[2] != 2'd0 && rx_bus_ready_in) [*8] |-> ##[0:8]
        (rx_bus_out.valid && rx_bus_chan_out == 3'd2);
  endproperty
  a_arb_served: assert property (p_arb_served)
    else $error("channel starved by arbiter");

  property p_slow_step;
    @(posedge core_clk_in) disable iff (!arst_n_in)
      (g_chan[0].st_q == MV_SETTLE) |-> !g_chan[0].tx_pop;
  endproperty
  a_slow_step: assert property (p_slow_step)
    else $error("pop while settling");

  c_burst: cover property (@(posedge core_clk_in) tx_lane_out[0].valid [*4]);
  c_settle: cover property (@(posedge core_clk_in) g_chan[0].st_q == MV_SETTLE);
  c_rx_full: cover property (@(posedge core_clk_in) rx_flags_out[3].full);
  c_bus_stall: cover property (@(posedge core_clk_in) rx_bus_out.valid && !rx_bus_ready_in);
endmodule // lane_mover

// ===== dv/user_side_model.sv
/*
  Behavioural user side: transmit target FIFOs and receive push engines.
  Assumes the mover's core clock and active-low reset; bench sets stalls.
*/
`timescale 1ns/1ps
module user_side_model
  import lane_mover_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
)(
  // Clock and reset
  input  wire logic                       core_clk_in,
  input  wire logic                       arst_n_in,
  // Bench controls
  input  wire logic        [CHANNELS-1:0] drain_in,
  input  wire logic        [CHANNELS-1:0] force_af_in,
  input  wire logic        [CHANNELS-1:0] force_full_in,
  input  wire logic        [CHANNELS-1:0] send_in,
  // Mover side
  input  wire lane_word_s  [CHANNELS-1:0] tx_lane_in,
  output lane_flags_s      [CHANNELS-1:0] tx_flags_out,
  output lane_word_s       [CHANNELS-1:0] rx_lane_out,
  input  wire lane_flags_s [CHANNELS-1:0] rx_flags_in
);
  logic [4:0] occ_q [CHANNELS];
  logic [4:0] seq_q [CHANNELS];

  always_ff @(posedge core_clk_in or negedge arst_n_in)
    for (int c = 0; c < CHANNELS; c++)
      if (!arst_n_in)
      begin
        occ_q[c] <= '0;
        seq_q[c] <= '0;
      end
      else
      begin
        // Target only absorbs pushes; drain is the user reader
        occ_q[c] <= occ_q[c] + 5'(tx_lane_in[c].valid)
                    - 5'(drain_in[c] && occ_q[c] != '0);
        if (rx_lane_out[c].valid)
          seq_q[c] <= seq_q[c] + 5'h1;
      end

  always_comb
    for (int c = 0; c < CHANNELS; c++)
    begin
      tx_flags_out[c].full        = force_full_in[c] || occ_q[c] >= DEPTH;
      tx_flags_out[c].almost_full = force_af_in[c]
                                    || occ_q[c] >= DEPTH - ALMOST_MARGIN;
      rx_lane_out[c].valid        = send_in[c] && !rx_flags_in[c].full;
      // Idle data inverted so a stale byte never looks valid
      rx_lane_out[c].data = rx_lane_out[c].valid ? {3'(c), seq_q[c]}
                                                 : ~{3'(c), seq_q[c]};
    end
endmodule // user_side_model

// ===== dv/inter_fpga_fifo_data_mover_tb.sv
/*
  Self-checking bench for the lane mover with the user-side model.
  Assumes the package constants; random data from a fixed-seed LFSR.
*/
`timescale 1ns/1ps
`define check_eq(got, exp) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); \
    end \
  end
module inter_fpga_fifo_data_mover_tb;
  import lane_mover_pkg::*;
  logic                       core_clk_in;
  logic                       arst_n_in;
  logic                       rx_bus_ready_in;
  lane_word_s  [CHANNELS-1:0] tx_fill_in;
  logic        [CHANNELS-1:0] tx_fill_ready_out;
  lane_word_s  [CHANNELS-1:0] tx_lane_out;
  lane_flags_s [CHANNELS-1:0] tx_target_flags_in;
  lane_word_s  [CHANNELS-1:0] rx_lane_in;
  lane_flags_s [CHANNELS-1:0] rx_flags_out;
  lane_word_s                 rx_bus_out;
  logic        [2:0]          rx_bus_chan_out;
  logic        [CHANNELS-1:0] drain, force_af, force_full, send;
  logic        [CHANNELS-1:0] prev_full = '0;
  logic        [BYTE_W-1:0]   exp_q [CHANNELS][$];
  logic        [BYTE_W-1:0]   exp_b;
  logic        [15:0]         rnd = 16'h000d;
  logic                       rx_full_seen = 1'b0;
  int                         rx_n [CHANNELS];
  int                         last_v [CHANNELS];
  int                         af_run [CHANNELS];
  int                         err_count, n_compared, cyc, bursts;

  lane_mover dut (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .tx_fill_in(tx_fill_in),
    .tx_fill_ready_out(tx_fill_ready_out), .tx_lane_out(tx_lane_out),
    .tx_target_flags_in(tx_target_flags_in), .rx_lane_in(rx_lane_in),
    .rx_flags_out(rx_flags_out), .rx_bus_out(rx_bus_out), .rx_bus_chan_out(rx_bus_chan_out),
    .rx_bus_ready_in(rx_bus_ready_in));
  user_side_model far_end (.core_clk_in(core_clk_in), .arst_n_in(arst_n_in), .drain_in(drain),
    .force_af_in(force_af), .force_full_in(force_full), .send_in(send),
    .tx_lane_in(tx_lane_out), .tx_flags_out(tx_target_flags_in), .rx_lane_out(rx_lane_in),
    .rx_flags_in(rx_flags_out));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic bit quiet();
    for (int c = 0; c < CHANNELS; c++)
      if (exp_q[c].size() != 0 || rx_flags_out[c].almost_full)
        return 1'b0;
    return !rx_bus_out.valid;
  endfunction

  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic settle(input string name);
    for (int n = 0; !quiet(); n++)
    begin
      if (n > 3000)
      begin
        err_count++;
        stop_test();
      end
      @(negedge core_clk_in);
    end
    $display("test %s done", name);
  endtask

  task automatic fill(input int n, input logic [CHANNELS-1:0] mask, input bit dense);
    repeat (n)
    begin
      @(negedge core_clk_in);
      for (int c = 0; c < CHANNELS; c++)
      begin
        rnd = lfsr_next(rnd);
        tx_fill_in[c].valid = mask[c] && (dense || rnd[9]);
        tx_fill_in[c].data  = rnd[7:0];
      end
    end
    @(negedge core_clk_in);
    tx_fill_in = '0;
  endtask

  initial
  begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end

  always @(posedge core_clk_in)
  begin
    cyc++;
    if (rx_bus_out.valid && rx_bus_ready_in)
    begin
      exp_b = {rx_bus_chan_out, 5'(rx_n[rx_bus_chan_out])};
      rx_n[rx_bus_chan_out]++;
      `check_eq(rx_bus_out.data, exp_b)
    end
    for (int c = 0; c < CHANNELS; c++)
    begin
      if (rx_flags_out[c].full)
        rx_full_seen = 1'b1;
      if (tx_fill_in[c].valid && tx_fill_ready_out[c])
        exp_q[c].push_back(tx_fill_in[c].data);
      if (tx_lane_out[c].valid)
      begin
        `check_eq(prev_full[c], 1'b0)
        if (af_run[c] >= 6)
          `check_eq(cyc - last_v[c] > SLOW_GAP, 1'b1)
        if (cyc - last_v[c] == 1)
          bursts++;
        last_v[c] = cyc;
        exp_b = exp_q[c].size() != 0 ? exp_q[c].pop_front() : 'x;
        `check_eq(tx_lane_out[c].data, exp_b)
      end
      af_run[c]    = tx_target_flags_in[c].almost_full ? af_run[c] + 1 : 0;
      prev_full[c] = tx_target_flags_in[c].full;
    end
  end

  initial
  begin
    {arst_n_in, tx_fill_in, force_af, force_full, send} = '0;
    rx_bus_ready_in = 1'b1;
    drain = '1;
    repeat (20) @(negedge core_clk_in);
    `check_eq(tx_lane_out, '0)
    arst_n_in = 1'b1;
    repeat (2) @(negedge core_clk_in);
    `check_eq(tx_fill_ready_out, 8'hff)
    fill(12, '1, 1'b1);
    settle("burst");
    `check_eq(bursts != 0, 1'b1)
    force_af = '1;
    fill(10, '1, 1'b0);
    settle("slow");
    force_af   = '0;
    force_full = 8'h01;
    fill(20, 8'h01, 1'b1);
    `check_eq(tx_fill_ready_out[0], 1'b0)
    force_full = '0;
    settle("stall");
    send = '1;
    repeat (200)
    begin
      @(negedge core_clk_in);
      rnd = lfsr_next(rnd);
      rx_bus_ready_in = rnd[0] & rnd[3];
    end
    send = '0;
    rx_bus_ready_in = 1'b1;
    settle("receive");
    `check_eq(rx_full_seen, 1'b1)
    for (int c = 0; c < CHANNELS; c++)
      `check_eq(rx_n[c] != 0, 1'b1)
    stop_test();
  end
endmodule // inter_fpga_fifo_data_mover_tb
